// *** hdl/fcps_ctrl.sv ***
// flash command sequencer, block protection, vector redirect and security
// assumes array reads return arr_rdata in the cycle arr.addr is shown
`timescale 1ns/1ps
`default_nettype none
// Operation
// - protected mass erase flags violation, else completes
// - access error blocks commands until cleared
// - address write before divider write errors
// - address write while buffer busy errors
// - second address or command write errors
// - stray control write mid-sequence errors
// - illegal command code errors
// - stop mode aborts running operation, errors
// - secured debug path only verify, mass erase
// - writing zero to buffer flag mid-sequence errors
// - protect from 512-byte boundary to top
// - protection loads at reset, debug-only writes
// - last unprotected address is select bits plus ones
// - redirect interrupt vectors when partly protected
// - secured foreign reads zero, foreign key-window writes dropped
// - only pattern 1:0 means unsecured
// - key access turns key writes into compares
// - key match on clear unsecures until reset
// - key writes honoured only from secure code
// - debug blank check success unsecures
// - verify sets blank only if all erased
module fcps_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // system bus
    input wire fcps_pkg::fcps_bus_t bus,
    output var logic [7:0] rd_data,
    output var logic [15:0] mem_addr,
    output var logic mem_zero,
    // nonvolatile images and key
    input wire logic [7:0] nv_prot,
    input wire logic [7:0] nv_opt,
    input wire logic [63:0] nv_key,
    // array engine
    output var fcps_pkg::fcps_arr_t arr,
    input wire logic arr_done,
    input wire logic [7:0] arr_rdata,
    // system state
    input wire logic stop_entry,
    output var logic secure
);
    import fcps_pkg::*;

    fcps_regs_t s;
    fcps_regs_t next_s;

    // ********************************
    // helpers
    // ********************************
    function automatic logic in_flash(input logic [15:0] a);
        return a >= FCPS_FLASH_LO;
    endfunction

    function automatic logic [15:0] last_open(input logic [7:0] p);
        return {p[7:1], FCPS_LOW_ONES};
    endfunction

    function automatic logic is_prot(input logic [7:0] p,
                                     input logic [15:0] a);
        return !p[FCPS_PROT_DIS] && (a > last_open(p));
    endfunction

    function automatic logic legal_cmd(input logic [7:0] c);
        return c == FCPS_CMD_VERIFY || c == FCPS_CMD_PROG ||
               c == FCPS_CMD_BURST || c == FCPS_CMD_SECTOR ||
               c == FCPS_CMD_MASS;
    endfunction

    logic sec_now;
    logic prot_on;
    logic partial;
    logic key_mode;
    logic err;
    logic launch;
    logic [15:0] last;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        next_s = s;
        err = 1'b0;
        launch = 1'b0;
        last = last_open(s.prot);
        sec_now = s.opt[1:0] != FCPS_SEC_OPEN;
        prot_on = !s.prot[FCPS_PROT_DIS];
        partial = prot_on && last >= FCPS_FLASH_LO;
        key_mode = s.key_access_bit && s.opt[FCPS_OPT_KEY_ENABLE_BIT];
        next_s.rd_data = 8'h00;
        next_s.mem_zero = 1'b0;
        next_s.mem_addr = bus.addr;
        // images are copied on the first cycle after reset
        if (!s.loaded) begin
            next_s.loaded = 1'b1;
            next_s.prot = nv_prot;
            next_s.opt = nv_opt;
        end
        // reads
        if (bus.rd) begin
            if (in_flash(bus.addr)) begin
                next_s.mem_zero = sec_now && (bus.bdm || !bus.secure_src);
                if (!s.opt[FCPS_OPT_NORED] && partial &&
                    bus.addr >= FCPS_VEC_LO && bus.addr <= FCPS_VEC_HI) begin
                    next_s.mem_addr = {last[15:6], bus.addr[5:0]};
                end
            end else if (bus.addr == FCPS_OFF_DIV) begin
                next_s.rd_data = {s.divld, s.div};
            end else if (bus.addr == FCPS_OFF_OPT) begin
                next_s.rd_data = s.opt;
            end else if (bus.addr == FCPS_OFF_CFG) begin
                next_s.rd_data[FCPS_CFG_KEY_ACCESS_BIT] = s.key_access_bit;
            end else if (bus.addr == FCPS_OFF_PROT) begin
                next_s.rd_data = s.prot;
            end else if (bus.addr == FCPS_OFF_STAT) begin
                next_s.rd_data[FCPS_ST_CBEF] = s.st == FCPS_IDLE;
                next_s.rd_data[FCPS_ST_CCF] = s.st == FCPS_IDLE;
                next_s.rd_data[FCPS_ST_PVIOL] = s.pviol;
                next_s.rd_data[FCPS_ST_ACCERR] = s.accerr;
                next_s.rd_data[FCPS_ST_BLANK] = s.blank;
            end else if (bus.addr == FCPS_OFF_CMD) begin
                next_s.rd_data = s.cmd;
            end
        end
        // writes
        if (bus.wr) begin
            if (key_mode && bus.addr[15:3] == FCPS_KEY_BASE[15:3]) begin
                if (!bus.bdm && bus.secure_src) begin
                    if (bus.addr[2:0] == s.key_idx[2:0] && !s.key_idx[3]) begin
                        next_s.key[{s.key_idx[2:0], 3'h0} +: 8] = bus.wdata;
                        next_s.key_idx = s.key_idx + 4'h1;
                    end else begin
                        next_s.key_bad = 1'b1;
                    end
                end
            end else if (in_flash(bus.addr)) begin
                if (s.accerr) begin
                    next_s.accerr = 1'b1;
                end else if (!s.divld) begin
                    err = 1'b1;
                end else if (s.st == FCPS_BUSY || s.st == FCPS_VERIFY) begin
                    err = 1'b1;
                end else if (s.st != FCPS_IDLE) begin
                    err = 1'b1;
                end else begin
                    next_s.st = FCPS_ADDR;
                    next_s.arr.addr = bus.addr;
                    next_s.arr.data = bus.wdata;
                end
            end else if (bus.addr == FCPS_OFF_CMD) begin
                if (s.st != FCPS_ADDR) begin
                    err = 1'b1;
                end else if (!legal_cmd(bus.wdata)) begin
                    err = 1'b1;
                end else if (sec_now && bus.bdm &&
                             (bus.wdata == FCPS_CMD_PROG ||
                              bus.wdata == FCPS_CMD_BURST ||
                              bus.wdata == FCPS_CMD_SECTOR)) begin
                    err = 1'b1;
                end else begin
                    next_s.st = FCPS_CMD;
                    next_s.cmd = bus.wdata;
                    next_s.cmd_bdm = bus.bdm;
                end
            end else if (bus.addr == FCPS_OFF_STAT) begin
                // flag clears by writing one
                if (bus.wdata[FCPS_ST_ACCERR]) begin
                    next_s.accerr = 1'b0;
                end
                if (bus.wdata[FCPS_ST_PVIOL]) begin
                    next_s.pviol = 1'b0;
                end
                if (s.st == FCPS_ADDR) begin
                    err = 1'b1;
                end else if (s.st == FCPS_CMD) begin
                    if (bus.wdata[FCPS_ST_CBEF]) begin
                        launch = 1'b1;
                    end else begin
                        err = 1'b1;
                    end
                end
            end else if (bus.addr == FCPS_OFF_DIV ||
                         bus.addr == FCPS_OFF_CFG ||
                         bus.addr == FCPS_OFF_PROT) begin
                if (s.st == FCPS_ADDR || s.st == FCPS_CMD) begin
                    err = 1'b1;
                end else if (bus.addr == FCPS_OFF_DIV) begin
                    if (!s.divld) begin
                        next_s.divld = 1'b1;
                        next_s.div = bus.wdata[6:0];
                    end
                end else if (bus.addr == FCPS_OFF_CFG) begin
                    next_s.key_access_bit = bus.wdata[FCPS_CFG_KEY_ACCESS_BIT];
                    next_s.key_idx = 4'h0;
                    next_s.key_bad = 1'b0;
                    if (s.key_access_bit && !bus.wdata[FCPS_CFG_KEY_ACCESS_BIT] &&
                        s.opt[FCPS_OPT_KEY_ENABLE_BIT] && !s.key_bad &&
                        s.key_idx == FCPS_KEY_LEN && s.key == nv_key) begin
                        next_s.opt[1:0] = FCPS_SEC_OPEN;
                    end
                end else if (bus.bdm) begin
                    next_s.prot = bus.wdata;
                end
            end
        end
        // launch with protection check
        if (launch) begin
            next_s.st = FCPS_BUSY;
            next_s.blank = 1'b0;
            unique case (s.cmd)
                FCPS_CMD_MASS: begin
                    if (prot_on) begin
                        next_s.pviol = 1'b1;
                        next_s.st = FCPS_IDLE;
                    end else begin
                        next_s.arr.mass = 1'b1;
                    end
                end
                FCPS_CMD_SECTOR: begin
                    if (is_prot(s.prot, {s.arr.addr[15:9], FCPS_LOW_ONES})) begin
                        next_s.pviol = 1'b1;
                        next_s.st = FCPS_IDLE;
                    end else begin
                        next_s.arr.sector = 1'b1;
                    end
                end
                FCPS_CMD_VERIFY: begin
                    next_s.st = FCPS_VERIFY;
                    next_s.arr.addr = FCPS_FLASH_LO;
                end
                default: begin
                    if (is_prot(s.prot, s.arr.addr)) begin
                        next_s.pviol = 1'b1;
                        next_s.st = FCPS_IDLE;
                    end else begin
                        next_s.arr.prog = 1'b1;
                    end
                end
            endcase
        end
        // running operations
        if (s.st == FCPS_BUSY && arr_done) begin
            next_s.st = FCPS_IDLE;
            next_s.arr.prog = 1'b0;
            next_s.arr.sector = 1'b0;
            next_s.arr.mass = 1'b0;
        end
        if (s.st == FCPS_VERIFY) begin
            if (arr_rdata != FCPS_ERASED) begin
                next_s.st = FCPS_IDLE;
            end else if (s.arr.addr == FCPS_FLASH_HI) begin
                next_s.st = FCPS_IDLE;
                next_s.blank = 1'b1;
                if (s.cmd_bdm) begin
                    next_s.opt[1:0] = FCPS_SEC_OPEN;
                end
            end else begin
                next_s.arr.addr = s.arr.addr + 16'h0001;
            end
        end
        if (stop_entry && (s.st == FCPS_BUSY || s.st == FCPS_VERIFY)) begin
            err = 1'b1;
            next_s.st = FCPS_IDLE;
            next_s.arr.prog = 1'b0;
            next_s.arr.sector = 1'b0;
            next_s.arr.mass = 1'b0;
        end
        // error sets win over a same-cycle clear
        // a running operation is not dropped, or its levels would hang
        if (err) begin
            next_s.accerr = 1'b1;
            if (s.st != FCPS_BUSY && s.st != FCPS_VERIFY) begin
                next_s.st = FCPS_IDLE;
            end
        end
        // working security state, registered for the output
        next_s.secure = next_s.opt[1:0] != FCPS_SEC_OPEN;
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.st <= FCPS_IDLE;
            s.prot <= 8'h01;
            s.secure <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flops
    assign rd_data = s.rd_data;
    assign mem_addr = s.mem_addr;
    assign mem_zero = s.mem_zero;
    assign arr = s.arr;
    assign secure = s.secure;
endmodule
`default_nettype wire

// *** hdl/fcps_pkg.sv ***
// constants and types for the flash command, protection and security block
// assumes an 8-bit system bus with a 16-bit address, one access per cycle
package fcps_pkg;
    // ********************************
    // memory map
    // ********************************
    localparam logic [15:0] FCPS_FLASH_LO = 16'hf000;
    localparam logic [15:0] FCPS_FLASH_HI = 16'hffff;
    localparam logic [15:0] FCPS_VEC_LO = 16'hffc0;
    localparam logic [15:0] FCPS_VEC_HI = 16'hfffd;
    localparam logic [15:0] FCPS_KEY_BASE = 16'hffb0;
    localparam logic [15:0] FCPS_PROTECTION_OPTION_IMAGE_ADDR = 16'hffbd;
    localparam logic [15:0] FCPS_NONVOLATILE_OPTION_IMAGE_ADDR = 16'hffbf;
    localparam logic [15:0] FCPS_OFF_DIV = 16'h1820;
    localparam logic [15:0] FCPS_OFF_OPT = 16'h1821;
    localparam logic [15:0] FCPS_OFF_CFG = 16'h1823;
    localparam logic [15:0] FCPS_OFF_PROT = 16'h1824;
    localparam logic [15:0] FCPS_OFF_STAT = 16'h1825;
    localparam logic [15:0] FCPS_OFF_CMD = 16'h1826;
    // ********************************
    // commands and fields
    // ********************************
    localparam logic [7:0] FCPS_CMD_VERIFY = 8'h05;
    localparam logic [7:0] FCPS_CMD_PROG = 8'h20;
    localparam logic [7:0] FCPS_CMD_BURST = 8'h25;
    localparam logic [7:0] FCPS_CMD_SECTOR = 8'h40;
    localparam logic [7:0] FCPS_CMD_MASS = 8'h41;
    localparam int FCPS_ST_CBEF = 7;
    localparam int FCPS_ST_CCF = 6;
    localparam int FCPS_ST_PVIOL = 5;
    localparam int FCPS_ST_ACCERR = 4;
    localparam int FCPS_ST_BLANK = 2;
    localparam int FCPS_OPT_KEY_ENABLE_BIT = 7;
    localparam int FCPS_OPT_NORED = 6;
    localparam int FCPS_CFG_KEY_ACCESS_BIT = 5;
    localparam int FCPS_PROT_DIS = 0;
    localparam logic [1:0] FCPS_SEC_OPEN = 2'h2;
    localparam logic [7:0] FCPS_ERASED = 8'hff;
    localparam logic [8:0] FCPS_LOW_ONES = 9'h1ff;
    localparam logic [3:0] FCPS_KEY_LEN = 4'h8;

    typedef enum logic [4:0] {
        FCPS_IDLE = 5'h01,
        FCPS_ADDR = 5'h02,
        FCPS_CMD = 5'h04,
        FCPS_BUSY = 5'h08,
        FCPS_VERIFY = 5'h10
    } fcps_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic bdm;
        logic secure_src;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fcps_bus_t;

    typedef struct packed {
        logic prog;
        logic sector;
        logic mass;
        logic [15:0] addr;
        logic [7:0] data;
    } fcps_arr_t;

    typedef struct packed {
        fcps_state_t st;
        logic loaded;
        logic accerr;
        logic pviol;
        logic blank;
        logic divld;
        logic [6:0] div;
        logic key_access_bit;
        logic [7:0] prot;
        logic [7:0] opt;
        logic [7:0] cmd;
        logic cmd_bdm;
        logic [63:0] key;
        logic [3:0] key_idx;
        logic key_bad;
        logic [7:0] rd_data;
        logic [15:0] mem_addr;
        logic mem_zero;
        logic secure;
        fcps_arr_t arr;
    } fcps_regs_t;
endpackage

// *** tb/fcps_array_model.sv ***
// array engine stand-in: fixed busy time, one programmable dirty byte
// assumes arr levels stay up until arr_done is seen
`timescale 1ns/1ps
`default_nettype none
module fcps_array_model (
    // clock
    input wire logic clk,
    // array side
    input wire fcps_pkg::fcps_arr_t arr,
    output logic arr_done,
    output logic [7:0] arr_rdata
);
    import fcps_pkg::*;
    logic [3:0] cnt = 4'h0;
    logic dirty = 1'b0;
    logic [15:0] daddr = 16'h0000;
    wire logic busy = arr.prog | arr.sector | arr.mass;
    // programmed byte reads zero, the rest erased
    assign arr_rdata = (dirty && arr.addr == daddr) ? 8'h00 : FCPS_ERASED;
    assign arr_done = busy && cnt == 4'hc;
    // slow enough for a stop to land mid-operation
    always_ff @(posedge clk) begin
        cnt <= busy ? cnt + 4'h1 : 4'h0;
        dirty <= arr_done ? arr.prog : dirty;
        daddr <= (arr_done && arr.prog) ? arr.addr : daddr;
    end
endmodule
`default_nettype wire

// *** tb/fcps_sva.sv ***
// checker for the flash command, protection and security block
// assumes it is bound to fcps_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module fcps_sva (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched ports
    input wire fcps_pkg::fcps_bus_t bus,
    input wire logic [15:0] mem_addr,
    input wire logic mem_zero,
    input wire fcps_pkg::fcps_arr_t arr,
    input wire logic arr_done,
    input wire logic stop_entry,
    input wire logic secure
);
    import fcps_pkg::*;
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic busy = arr.prog | arr.sector | arr.mass;
    property p_launch;
        $rose(arr.mass) |-> $past(bus.wr) && $past(bus.wdata[7])
            && $past(bus.addr) == FCPS_OFF_STAT;
    endproperty
    a_launch: assert property (p_launch) else $error("erase without launch");
    property p_hold;
        arr.mass && !arr_done && !stop_entry |=> arr.mass;
    endproperty
    a_hold: assert property (p_hold) else $error("erase dropped early");
    property p_stop;
        busy && stop_entry |=> !busy;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");
    property p_zero;
        bus.rd && secure && (bus.bdm || !bus.secure_src)
            && bus.addr >= FCPS_FLASH_LO |=> mem_zero;
    endproperty
    a_zero: assert property (p_zero) else $error("foreign read not zeroed");
    property p_open;
        bus.rd && !secure |=> !mem_zero;
    endproperty
    a_open: assert property (p_open) else $error("open read zeroed");
    property p_rst_vec;
        bus.rd && bus.addr == 16'hfffe |=> mem_addr == 16'hfffe;
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("reset vector moved");
    property p_plain;
        bus.rd && bus.addr < FCPS_VEC_LO |=> mem_addr == $past(bus.addr);
    endproperty
    a_plain: assert property (p_plain) else $error("plain read moved");
    property p_sticky;
        !secure |=> !secure;
    endproperty
    a_sticky: assert property (p_sticky) else $error("security came back");
    c_mass: cover property ($rose(arr.mass));
    c_zero: cover property (mem_zero);
    c_unlock: cover property ($fell(secure));
    c_stop: cover property (busy && stop_entry);
endmodule
`default_nettype wire

// *** tb/tb_flash_command_protect_secure.sv ***
// self-checking bench for the flash command, protection and security block
// assumes the array stand-in answers twelve cycles after each launch
`timescale 1ns/1ps
`default_nettype none
module tb_flash_command_protect_secure;
    import fcps_pkg::*;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] launch;
        logic [7:0] exp;
    } fcps_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    fcps_bus_t bus = '0;
    logic [7:0] nv_prot = 8'hff;
    logic [7:0] nv_opt = 8'h82;
    logic [63:0] nv_key = 64'h8877665544332211;
    logic stop_entry = 1'b0;
    logic [7:0] rd_data, arr_rdata, rv;
    logic [15:0] mem_addr, ma;
    logic mem_zero, secure, arr_done, mz, bz;
    fcps_arr_t arr;
    int bad_count = 0;
    int total_checks = 0;
    fcps_row_t rows [9] = '{'{8'h20, 8'h80, 8'hc0}, '{8'h05, 8'h80, 8'hc0},
        '{8'h40, 8'h80, 8'hc0}, '{8'h41, 8'h80, 8'hc0},
        '{8'h05, 8'h80, 8'hc4}, '{8'h25, 8'h80, 8'hc0},
        '{8'h20, 8'h00, 8'hd0}, '{8'h00, 8'h80, 8'hd0},
        '{8'h42, 8'h80, 8'hd0}};
    fcps_ctrl fcps_ctrl_i (.clk, .nrst, .bus, .rd_data, .mem_addr, .mem_zero,
        .nv_prot, .nv_opt, .nv_key, .arr, .arr_done, .arr_rdata,
        .stop_entry, .secure);
    fcps_array_model fcps_array_model_i (.clk, .arr, .arr_done, .arr_rdata);
    always #50 clk = ~clk;
    // ****************
    // tasks
    // ****************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one access, an idle cycle after it
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic dbg, input logic src);
        bus <= '{wr: w, rd: !w, bdm: dbg, secure_src: src, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1 rv = rd_data;
        ma = mem_addr;
        mz = mem_zero;
        bz = arr.prog | arr.sector | arr.mass;
        @(posedge clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 1'b0, 1'b1);
    endtask
    task automatic rdr(input logic [15:0] a);
        acc(1'b0, a, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic seq(input logic [15:0] a, input logic [7:0] code,
                       input logic [7:0] launch, input logic dbg);
        acc(1'b1, a, 8'h00, dbg, !dbg);
        acc(1'b1, FCPS_OFF_CMD, code, dbg, !dbg);
        acc(1'b1, FCPS_OFF_STAT, launch, dbg, !dbg);
    endtask
    task automatic settle;
        int i;
        i = 0;
        rv = 8'h00;
        while (!rv[6] && i < 3000) begin
            rdr(FCPS_OFF_STAT);
            i++;
        end
    endtask
    task automatic key(input logic dbg);
        acc(1'b1, FCPS_OFF_CFG, 8'h20, dbg, !dbg);
        for (int k = 0; k < 8; k++)
            acc(1'b1, FCPS_KEY_BASE + 16'(k), nv_key[8*k +: 8], dbg, !dbg);
        acc(1'b1, FCPS_OFF_CFG, 8'h00, dbg, !dbg);
    endtask
    task automatic restart(input logic [7:0] p, input logic [7:0] o);
        nrst <= 1'b0;
        nv_prot <= p;
        nv_opt <= o;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        restart(8'hff, 8'h82);
        wr(16'hf100, 8'h00);
        rdr(FCPS_OFF_STAT);
        check(rv[4], 1'b1);
        wr(FCPS_OFF_DIV, 8'h31);
        seq(16'hf100, FCPS_CMD_MASS, 8'h80, 1'b0);
        rdr(FCPS_OFF_STAT);
        check({bz, rv[4]}, 2'b01);
        wr(FCPS_OFF_STAT, 8'h30);
        wr(16'hf100, 8'h00);
        wr(16'hf101, 8'h00);
        rdr(FCPS_OFF_STAT);
        check(rv[4], 1'b1);
        wr(FCPS_OFF_STAT, 8'h30);
        wr(16'hf100, 8'h00);
        wr(FCPS_OFF_CFG, 8'h00);
        rdr(FCPS_OFF_STAT);
        check(rv[4], 1'b1);
        foreach (rows[i]) begin
            wr(FCPS_OFF_STAT, 8'h30);
            seq(16'hf100, rows[i].code, rows[i].launch, 1'b0);
            settle();
            check(rv[7:4], rows[i].exp[7:4]);
            if (rows[i].code == FCPS_CMD_VERIFY)
                check(rv[2], rows[i].exp[2]);
        end
        // busy-time address write, then stop
        wr(FCPS_OFF_STAT, 8'h30);
        seq(16'hf100, FCPS_CMD_PROG, 8'h80, 1'b0);
        wr(16'hf102, 8'h00);
        rdr(FCPS_OFF_STAT);
        check(rv[4], 1'b1);
        wr(FCPS_OFF_STAT, 8'h30);
        stop_entry <= 1'b1;
        rdr(FCPS_OFF_STAT);
        stop_entry <= 1'b0;
        rdr(FCPS_OFF_STAT);
        check({bz, rv[4]}, 2'b01);
        // secured part, top 512 bytes protected
        restart(8'hfc, 8'h83);
        check(secure, 1'b1);
        rdr(FCPS_OFF_PROT);
        check(rv, 8'hfc);
        wr(FCPS_OFF_DIV, 8'h31);
        seq(16'hf100, FCPS_CMD_MASS, 8'h80, 1'b0);
        rdr(FCPS_OFF_STAT);
        check({bz, rv[5]}, 2'b01);
        wr(FCPS_OFF_STAT, 8'h30);
        seq(16'hfe00, FCPS_CMD_PROG, 8'h80, 1'b0);
        rdr(FCPS_OFF_STAT);
        check({bz, rv[5]}, 2'b01);
        wr(FCPS_OFF_STAT, 8'h30);
        seq(16'hfdff, FCPS_CMD_PROG, 8'h80, 1'b0);
        rdr(FCPS_OFF_STAT);
        check({bz, rv[5]}, 2'b10);
        settle();
        rdr(16'hffd0);
        check(ma, 16'hfdd0);
        rdr(16'hfffe);
        check(ma, 16'hfffe);
        acc(1'b0, 16'hf100, 8'h00, 1'b0, 1'b0);
        check(mz, 1'b1);
        wr(FCPS_OFF_PROT, 8'hff);
        rdr(FCPS_OFF_PROT);
        check(rv, 8'hfc);
        acc(1'b1, FCPS_OFF_PROT, 8'hff, 1'b1, 1'b0);
        rdr(FCPS_OFF_PROT);
        check(rv, 8'hff);
        wr(FCPS_OFF_STAT, 8'h30);
        seq(16'hf100, FCPS_CMD_PROG, 8'h80, 1'b1);
        rdr(FCPS_OFF_STAT);
        check(rv[4], 1'b1);
        wr(FCPS_OFF_STAT, 8'h30);
        key(1'b1);
        check(secure, 1'b1);
        key(1'b0);
        check(secure, 1'b0);
        // debug path unlock: mass erase, then blank check
        restart(8'hff, 8'h83);
        wr(FCPS_OFF_DIV, 8'h31);
        seq(16'hf100, FCPS_CMD_MASS, 8'h80, 1'b1);
        settle();
        check(secure, 1'b1);
        seq(16'hf100, FCPS_CMD_VERIFY, 8'h80, 1'b1);
        settle();
        check(rv[2], 1'b1);
        check(secure, 1'b0);
        close_out();
    end
    // hang guard, well past the longest erase verify
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule
bind fcps_ctrl fcps_sva fcps_sva_i (.clk, .nrst, .bus, .mem_addr, .mem_zero,
    .arr, .arr_done, .stop_entry, .secure);
`default_nettype wire
